/* rtl/lpec_pkg.sv */
// Overview of operation
// - Four independent 16-bit counters: violations, zero runs, framing, checksum errors.
// - Results update once a second, on a software bit, or on a pin.
// - A counter stops at all ones and never wraps.
// - Count same-polarity mark pairs unless they belong to a B8ZS substitution word.
// - Eight or more consecutive zero symbols make one zero-run event.
// - One unbroken zero run counts once, however long it lasts.
// - Framing counter counts frame losses when select is 0, F-bit errors when 1.
// - In loss mode the framing counter rises by one per loss of sync.
// - In F-bit mode a control bit keeps or suppresses counting during frame loss.
// - Checksum errors are counted; same control bit suppresses them during frame loss.
// - Frame loss is declared after seven consecutive multiframes with errored alignment.
// - Frame loss ends after three consecutive multiframes with correct alignment.
package lpec_pkg;

  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // register indices; byte address is four times the index
  localparam logic [5:0] VIOL_IDX = 6'h18;
  localparam logic [5:0] ZRUN_IDX = 6'h1A;
  localparam logic [5:0] FEC_IDX = 6'h1C;
  localparam logic [5:0] CRC_IDX = 6'h1E;
  localparam logic [5:0] CTRL_IDX = 6'h14;
  localparam logic [5:0] STAT_IDX = 6'h15;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MANUAL_BIT = 2;
  localparam int CTRL_FECS_BIT = 3;
  localparam int CTRL_KEEP_BIT = 4;
  localparam int STAT_FLOSS_BIT = 0;

  localparam int C_VIOL = 0;
  localparam int C_ZRUN = 1;
  localparam int C_FEC = 2;
  localparam int C_CRC = 3;

  localparam logic [3:0] ZERO_RUN_LEN = 4'h8;
  localparam logic [2:0] LOSS_SET_MF = 3'h7;
  localparam logic [1:0] LOSS_CLR_MF = 2'h3;

  localparam int UPDATE_PERIOD_MS = 1000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int UPDATE_CYCLES = UPDATE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TIMER_W = 27;

  typedef enum logic [1:0] {
    LPEC_UPD_AUTO,
    LPEC_UPD_SOFT,
    LPEC_UPD_PIN
  } lpec_upd_mode_e;

  typedef struct packed {
    logic crc;
    logic fec;
    logic zero_run_event;
    logic code_violation;
  } lpec_evt_s;

  typedef struct packed {
    logic mark;
    logic pol;
    logic viol;
  } lpec_sym_s;

  typedef struct packed {
    logic wait_req;
    logic [31:0] rdata;
    lpec_upd_mode_e mode;
    logic fecs;
    logic keep;
    logic manual;
    logic [2:0] pin_sync;
    logic [TIMER_W-1:0] timer;
    logic last_pol;
    logic seen_mark;
    lpec_sym_s [7:0] hist;
    logic [3:0] zrun;
    logic [2:0] err_mf;
    logic [1:0] good_mf;
    logic floss;
    logic [3:0][15:0] acc;
    logic [3:0][15:0] shadow;
  } lpec_state_s;

  localparam lpec_state_s STATE_RESET = '{wait_req: 1'b1, mode: LPEC_UPD_AUTO, default: '0};

  function automatic logic [15:0] lpec_sat_inc(input logic [15:0] v, input logic ev);
    return (ev && v != CNT_MAX) ? v + 16'h0001 : v;
  endfunction

endpackage

/* rtl/lpec_top.sv */
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
module lpec_top import lpec_pkg::*; #(
  parameter int UPDATE_CYCLES_P = UPDATE_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic line_pos_in,
  input wire logic line_neg_in,
  input wire logic mf_strobe_in,
  input wire logic fas_error_in,
  input wire logic fbit_error_in,
  input wire logic crc_error_in,
  input wire logic counter_update_pin_in,
  output logic frame_loss_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_q;
  logic rst_n;
  lpec_state_s q;
  lpec_state_s d;
  lpec_evt_s ev;
  logic upd;
  logic pin_rise;
  logic timer_wrap;
  logic mark;
  logic viol_new;
  logic loss_ev;
  logic b8zs_hit;
  lpec_sym_s [7:0] win;
  logic [3:0][15:0] inc;

  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // line symbol decode and substitution-word window
  assign mark = line_pos_in | line_neg_in;
  assign viol_new = mark & q.seen_mark & (line_pos_in == q.last_pol);
  assign win = {q.hist[6:0], lpec_sym_s'{mark: mark, pol: line_pos_in, viol: viol_new}};
  // pattern 000VB0VB, oldest symbol at index 7
  assign b8zs_hit = !win[7].mark && !win[6].mark && !win[5].mark && !win[2].mark &&
                    win[4].mark && win[3].mark && win[1].mark && win[0].mark &&
                    win[4].viol && win[1].viol &&
                    (win[3].pol != win[4].pol) && (win[0].pol != win[1].pol);

  assign pin_rise = q.pin_sync[1] & ~q.pin_sync[2];
  assign timer_wrap = (q.mode == LPEC_UPD_AUTO) && (q.timer == TIMER_W'(UPDATE_CYCLES_P - 1));
  assign upd = timer_wrap || ((q.mode == LPEC_UPD_SOFT) && q.manual) ||
               ((q.mode == LPEC_UPD_PIN) && pin_rise);
  assign loss_ev = !q.floss && mf_strobe_in && fas_error_in && (q.err_mf == LOSS_SET_MF - 3'h1);

  // violation counting lags the line by the eight-symbol window so a substitution word can be cancelled
  assign ev.code_violation = q.hist[7].viol;
  assign ev.zero_run_event = !mark && (q.zrun == ZERO_RUN_LEN - 4'h1);
  assign ev.fec = q.fecs ? (fbit_error_in && (q.keep || !q.floss)) : loss_ev;
  assign ev.crc = crc_error_in && (q.keep || !q.floss);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      inc[i] = lpec_sat_inc(q.acc[i], ev[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    // bus: one wait cycle, then waitrequest drops for exactly one edge
    d.wait_req = !((avs_read_in || avs_write_in) && q.wait_req);
    d.manual = 1'b0;
    if (avs_read_in && q.wait_req) begin
      unique case (avs_address_in[7:2])
        VIOL_IDX: d.rdata = {16'h0000, q.shadow[C_VIOL]};
        ZRUN_IDX: d.rdata = {16'h0000, q.shadow[C_ZRUN]};
        FEC_IDX: d.rdata = {16'h0000, q.shadow[C_FEC]};
        CRC_IDX: d.rdata = {16'h0000, q.shadow[C_CRC]};
        CTRL_IDX: begin
          d.rdata = 32'h0000_0000;
          d.rdata[CTRL_MODE_LSB +: 2] = q.mode;
          d.rdata[CTRL_FECS_BIT] = q.fecs;
          d.rdata[CTRL_KEEP_BIT] = q.keep;
        end
        STAT_IDX: begin
          d.rdata = 32'h0000_0000;
          d.rdata[STAT_FLOSS_BIT] = q.floss;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_in && !q.wait_req && avs_address_in[7:2] == CTRL_IDX) begin
      unique case (avs_writedata_in[CTRL_MODE_LSB +: 2])
        2'h1: d.mode = LPEC_UPD_SOFT;
        2'h2: d.mode = LPEC_UPD_PIN;
        default: d.mode = LPEC_UPD_AUTO;
      endcase
      d.fecs = avs_writedata_in[CTRL_FECS_BIT];
      d.keep = avs_writedata_in[CTRL_KEEP_BIT];
      d.manual = avs_writedata_in[CTRL_MANUAL_BIT];
    end

    // external update pin crosses through two flops before the edge detector
    d.pin_sync = {q.pin_sync[1:0], counter_update_pin_in};

    if (q.mode != LPEC_UPD_AUTO || timer_wrap) begin
      d.timer = '0;
    end else begin
      d.timer = q.timer + TIMER_W'(1);
    end

    // polarity tracking for violations
    if (mark) begin
      d.last_pol = line_pos_in;
      d.seen_mark = 1'b1;
    end
    d.hist = win;
    if (b8zs_hit) begin
      for (int i = 0; i < 8; i++) begin
        d.hist[i].viol = 1'b0;
      end
    end

    // zero run length saturates so a long run fires only once
    if (mark) begin
      d.zrun = 4'h0;
    end else if (q.zrun != ZERO_RUN_LEN) begin
      d.zrun = q.zrun + 4'h1;
    end

    // frame alignment supervision per multiframe
    if (mf_strobe_in) begin
      if (fas_error_in) begin
        d.good_mf = 2'h0;
        if (q.err_mf != LOSS_SET_MF) begin
          d.err_mf = q.err_mf + 3'h1;
        end
        if (loss_ev) begin
          d.floss = 1'b1;
        end
      end else begin
        d.err_mf = 3'h0;
        if (q.good_mf != LOSS_CLR_MF) begin
          d.good_mf = q.good_mf + 2'h1;
        end
        if (q.floss && q.good_mf == LOSS_CLR_MF - 2'h1) begin
          d.floss = 1'b0;
        end
      end
    end

    // event in the update cycle goes into the published value, not lost
    for (int i = 0; i < 4; i++) begin
      if (upd) begin
        d.shadow[i] = inc[i];
        d.acc[i] = CNT_RESET;
      end else begin
        d.acc[i] = inc[i];
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata_out = q.rdata;
  assign avs_waitrequest_out = q.wait_req;
  assign frame_loss_out = q.floss;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n);

  sequence s_zero_run;
    mark ##1 (!mark) [*8];
  endsequence

  sequence s_b8zs_seen;
    b8zs_hit;
  endsequence

  a_bus_wait_once: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("waitrequest did not drop after one cycle");

  a_sat_hold_max: assert property (q.acc[C_CRC] == CNT_MAX && !upd |=> q.acc[C_CRC] == CNT_MAX)
    else $error("checksum accumulator left its maximum");

  a_upd_copy_restart: assert property (upd |=> q.shadow[C_VIOL] == $past(inc[C_VIOL]) &&
                                       q.acc[C_VIOL] == CNT_RESET && q.acc[C_ZRUN] == CNT_RESET)
    else $error("update did not copy and restart accumulators");

  a_zero_run_hit: assert property (s_zero_run |-> ev.zero_run_event)
    else $error("eight zeros did not raise a zero-run event");

  a_zero_run_once: assert property (ev.zero_run_event ##1 !mark |-> !ev.zero_run_event)
    else $error("zero run counted twice");

  a_b8zs_cancel: assert property (s_b8zs_seen |=> (!ev.code_violation) [*8])
    else $error("substitution word produced a violation count");

  a_loss_declared: assert property (!q.floss && mf_strobe_in && fas_error_in && q.err_mf == 3'h6
                                    |=> frame_loss_out && q.err_mf == LOSS_SET_MF)
    else $error("frame loss not declared after seven errored multiframes");

  a_loss_cleared: assert property (q.floss && mf_strobe_in && !fas_error_in && q.good_mf == 2'h2
                                   |=> !frame_loss_out)
    else $error("frame loss not cleared after three good multiframes");

  a_fec_loss_mode: assert property (!q.fecs && fbit_error_in && !loss_ev && !upd
                                    |=> q.acc[C_FEC] == $past(q.acc[C_FEC]))
    else $error("F-bit error counted in loss mode");

  a_fec_loss_step: assert property (!q.fecs && loss_ev && !upd && q.acc[C_FEC] != CNT_MAX
                                    |=> q.acc[C_FEC] == $past(q.acc[C_FEC]) + 16'h0001)
    else $error("frame loss not counted once");

  a_fbit_suppress: assert property (q.fecs && q.floss && !q.keep && !upd
                                    |=> q.acc[C_FEC] == $past(q.acc[C_FEC]))
    else $error("F-bit errors counted during frame loss");

  a_crc_suppress: assert property (q.floss && !q.keep && !upd
                                   |=> q.acc[C_CRC] == $past(q.acc[C_CRC]))
    else $error("checksum errors counted during frame loss");

  a_auto_update: assert property (timer_wrap |=> q.timer == '0 && q.acc[C_ZRUN] == CNT_RESET)
    else $error("one-second update missing");

  a_pin_update: assert property (q.mode == LPEC_UPD_PIN && pin_rise |=> q.acc[C_CRC] == CNT_RESET)
    else $error("pin update missing");

endmodule

/* dv/lpec_line_model.sv */
`timescale 1ns/1ps
module lpec_line_model (
  input wire logic clk_in,
  output logic pos_out,
  output logic neg_out,
  output logic mf_out,
  output logic fas_out,
  output logic fbit_out,
  output logic crc_out
);
  // symbol codes: 0 no pulse, 1 alternating mark, 2 mark repeating the last polarity
  logic [1:0] q[$];
  logic [1:0] c;
  logic np;
  logic last = 1'b0;
  initial begin
    {pos_out, neg_out, mf_out, fas_out, fbit_out, crc_out} = 6'h00;
  end
  // an idle line keeps alternating marks, so no zero run appears unless asked for
  always @(posedge clk_in) begin
    c = (q.size() > 0) ? q.pop_front() : 2'h1;
    np = (c == 2'h1) ? ~last : last;
    pos_out <= (c != 2'h0) && np;
    neg_out <= (c != 2'h0) && !np;
    if (c != 2'h0) last <= np;
  end
  task push(input logic [1:0] s, input int n);
    repeat (n) q.push_back(s);
  endtask
  // the violation decision lags its symbol, so let the line settle before returning
  task drain();
    while (q.size() > 0) @(posedge clk_in);
    repeat (12) @(posedge clk_in);
  endtask
  task strobe(input logic fas, input int n);
    repeat (n) begin
      @(posedge clk_in);
      mf_out <= 1'b1;
      fas_out <= fas;
      @(posedge clk_in);
      mf_out <= 1'b0;
      fas_out <= ~fas;
    end
  endtask
  task pulse(input logic crc, input int n);
    repeat (n) begin
      @(posedge clk_in);
      crc_out <= crc;
      fbit_out <= ~crc;
      @(posedge clk_in);
      crc_out <= 1'b0;
      fbit_out <= 1'b0;
    end
  endtask
  task hold(input int n);
    @(posedge clk_in);
    crc_out <= 1'b1;
    repeat (n) @(posedge clk_in);
    crc_out <= 1'b0;
  endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top import lpec_pkg::*; ;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic counter_update_pin_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out, q, ctrl_v;
  logic avs_waitrequest_out, frame_loss_out, line_pos_in, line_neg_in;
  logic mf_strobe_in, fas_error_in, fbit_error_in, crc_error_in;
  int failures = 0, checks = 0, cyc = 0, k, v;
  lpec_top #(.UPDATE_CYCLES_P(50)) uut (.clk_sys_in, .arst_n_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .line_pos_in,
    .line_neg_in, .mf_strobe_in, .fas_error_in, .fbit_error_in, .crc_error_in,
    .counter_update_pin_in, .frame_loss_out);
  lpec_line_model u_line (.clk_in(clk_sys_in), .pos_out(line_pos_in), .neg_out(line_neg_in),
    .mf_out(mf_strobe_in), .fas_out(fas_error_in), .fbit_out(fbit_error_in), .crc_out(crc_error_in));
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 90000) begin
      failures++;
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task stop_test();
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= ~w;
    do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task rd4(input logic [15:0] b, input logic [15:0] z, input logic [15:0] f, input logic [15:0] c);
    rd(8'h60, {16'h0000, b});
    rd(8'h68, {16'h0000, z});
    rd(8'h70, {16'h0000, f});
    rd(8'h78, {16'h0000, c});
  endtask
  task wr_ctrl(input logic [31:0] d);
    ctrl_v = d;
    av(1'b1, 8'h50, d);
  endtask
  task upd();
    u_line.drain();
    av(1'b1, 8'h50, ctrl_v | 32'h4);
    repeat (3) @(posedge clk_sys_in);
  endtask
  task loss_is(input logic e);
    repeat (2) @(posedge clk_sys_in);
    #1;
    chk(frame_loss_out, e);
  endtask
  function automatic logic [15:0] sat(input int n);
    return (n > 65535) ? CNT_MAX : n[15:0];
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(18));
    repeat (6) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rd4(16'h0, 16'h0, 16'h0, 16'h0);
    rd(8'hFC, 32'h0);
    wr_ctrl(32'h3);
    rd(8'h50, 32'h0);
    wr_ctrl(32'h1);
    upd();
    v = $urandom_range(1, 6);
    for (int i = 0; i < v; i++) begin
      u_line.push(2'h2, 1);
      u_line.push(2'h1, 4);
    end
    // substitution word 000VB0VB must not count
    u_line.push(2'h0, 3);
    u_line.push(2'h2, 1);
    u_line.push(2'h1, 1);
    u_line.push(2'h0, 1);
    u_line.push(2'h2, 1);
    u_line.push(2'h1, 1);
    for (int n = 7; n <= 9; n++) begin
      u_line.push(2'h0, (n == 9) ? 20 : n);
      u_line.push(2'h1, 2);
    end
    k = $urandom_range(1, 9);
    u_line.pulse(1'b1, k);
    upd();
    rd4(v, 16'h2, 16'h0, k);
    upd();
    rd4(16'h0, 16'h0, 16'h0, 16'h0);
    // checksum error lands on the very edge of the manual update
    fork
      upd();
      begin
        repeat (14) @(posedge clk_sys_in);
        u_line.pulse(1'b1, 1);
      end
    join
    rd(8'h78, 32'h1);
    u_line.strobe(1'b1, 6);
    u_line.strobe(1'b0, 1);
    u_line.strobe(1'b1, 6);
    loss_is(1'b0);
    u_line.strobe(1'b1, 1);
    loss_is(1'b1);
    rd(8'h54, 32'h1);
    u_line.pulse(1'b0, 3);
    u_line.pulse(1'b1, 2);
    upd();
    rd4(16'h0, 16'h0, 16'h1, 16'h0);
    wr_ctrl(32'h19);
    rd(8'h50, 32'h19);
    k = $urandom_range(1, 9);
    u_line.pulse(1'b0, k);
    u_line.pulse(1'b1, k);
    upd();
    rd4(16'h0, 16'h0, k, k);
    wr_ctrl(32'h9);
    u_line.pulse(1'b0, 3);
    u_line.strobe(1'b0, 2);
    loss_is(1'b1);
    u_line.strobe(1'b0, 1);
    loss_is(1'b0);
    u_line.pulse(1'b0, 1);
    u_line.pulse(1'b1, 1);
    upd();
    rd4(16'h0, 16'h0, 16'h1, 16'h1);
    wr_ctrl(32'h0);
    k = $urandom_range(1, 9);
    u_line.pulse(1'b1, k);
    repeat (50) @(posedge clk_sys_in);
    rd(8'h78, k);
    wr_ctrl(32'h2);
    u_line.pulse(1'b1, 3);
    counter_update_pin_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    counter_update_pin_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rd(8'h78, 32'h3);
    wr_ctrl(32'h1);
    u_line.hold(65540);
    upd();
    rd(8'h78, sat(65540));
    av(1'b1, 8'h78, 32'h0);
    rd(8'h78, CNT_MAX);
    stop_test();
  end
endmodule
